// File: logic/cpm_regs.vh
/*
 constants for the can controller pin function mux: register offsets,
 field positions, reset values and interface mode codes.
 assumes inclusion by bare name from the design files.
*/
`ifndef CPM_REGS_VH
`define CPM_REGS_VH
// register offsets on the internal register port
`define CPM_OFS_CPU_IF 8'h02
`define CPM_OFS_P1_SETUP_A 8'h9f
`define CPM_OFS_P1_SETUP_B 8'haf
// port 2 data and direction, own offsets
`define CPM_OFS_P2_DATA 8'hb0
`define CPM_OFS_P2_DIR 8'hb1
`define CPM_OFS_P1_DATA 8'hb2
// bus configuration, own offset
`define CPM_OFS_BUS_CFG 8'h2f
`define CPM_OFS_CLK_CFG 8'h1f
// field positions
`define CPM_BIT_INT_PIN_SEL 5
`define CPM_BIT_COMP_BYPASS 0
// reset values
`define CPM_RST_CPU_IF 8'h00
`define CPM_RST_BYTE 8'h00
`define CPM_RST_CLK_DIV 4'h0
// interface mode codes
`define CPM_MODE_MUX16 2'h0
`define CPM_MODE_MUX8 2'h1
`define CPM_MODE_NONMUX8 2'h2
`define CPM_MODE_SERIAL 2'h3
// warm reset least time, in us, and cycles at 100 mhz
`define CPM_WARM_RST_US 1000
`define CPM_CLK_MHZ 100
`define CPM_WARM_RST_CYC (`CPM_WARM_RST_US * `CPM_CLK_MHZ)
`endif

// File: logic/cpm_line_codec.v
/*
 can line codec: receive comparator with bypass and complementary
 transmit pair. assumes rx inputs are already digital comparator results
 sampled on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module cpm_line_codec (
  input wire core_clk,
  input wire rst,
  input wire rx_line_first,
  input wire rx_line_second,
  input wire comparator_bypass,
  input wire tx_bit,
  output reg rx_bit,
  output reg tx_drive_first,
  output reg tx_drive_second
);
  // receive decode and transmit drive, registered
  always @(posedge core_clk) begin
    if (rst) begin
      rx_bit <= 1'b1;
      tx_drive_first <= 1'b1;
      tx_drive_second <= 1'b0;
    end else begin
      if (comparator_bypass) begin
        // bypass: first line alone gives the level
        rx_bit <= rx_line_first;
      end else if (rx_line_first != rx_line_second) begin
        // first above second reads recessive (1), else dominant
        rx_bit <= rx_line_first & ~rx_line_second;
      end
      // recessive: high/low; dominant: low/high
      tx_drive_first <= tx_bit;
      tx_drive_second <= ~tx_bit;
    end
  end
endmodule // cpm_line_codec
`default_nettype wire

// File: logic/cpm_clk_div.v
/*
 programmable clock output divider: produces a divided clock level and
 a one-cycle enable pulse. assumes a single core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module cpm_clk_div #(
  parameter W = 4
) (
  input wire core_clk,
  input wire rst,
  input wire [W-1:0] div_sel,
  output reg clk_level,
  output reg tick
);
  reg [W-1:0] count; // cycles since last toggle
  // toggle the output every div_sel+1 cycles
  always @(posedge core_clk) begin
    if (rst) begin
      count <= {W{1'b0}};
      clk_level <= 1'b0;
      tick <= 1'b0;
    end else if (count >= div_sel) begin
      count <= {W{1'b0}};
      clk_level <= ~clk_level;
      tick <= 1'b1;
    end else begin
      count <= count + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule // cpm_clk_div
`default_nettype wire

// File: logic/cpm_pin_mux.v
/*
 pin function mux for a can controller: host bus pin assignment per
 interface mode, chip-select gating, interrupt pin relocation, port 1
 and port 2 general io, line codec and clock output.
 assumes all inputs synchronous to core_clk and an internal register
 port driven by the host bus decoder of the surrounding chip.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cpm_regs.vh"
// Function
// - rx first above second reads recessive
// - bypass bit takes level from first input
// - recessive drives high/low, dominant low/high
// - select bit moves interrupt off default pin
// - interrupt is open-drain active low
// - select set: port 2 bit 6 is interrupt
// - host access only while chip select low
// - low pins: address/data, address, or low byte
// - serial mode reassigns low pins to configuration
// - high pins: data, high byte, or port 1
// - port 1 pull-ups until both setups written
// - port 2 general io, bit 7 high write
// - device provides programmable clock output
// - serial mode readiness pin carries data out
module cpm_pin_mux #(
  parameter CLK_DIV_W = 4
) (
  input wire core_clk,
  input wire rst,
  // interface mode straps
  input wire [1:0] if_mode,
  // host bus control
  input wire chip_select_n,
  // internal register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // core side data for the host bus pins
  input wire [15:0] core_bus_out,
  input wire core_bus_oe,
  output wire [15:0] core_bus_in,
  output wire host_access,
  input wire ready_in,
  input wire serial_data_out,
  input wire int_req,
  input wire high_byte_write_en,
  // host bus pins
  input wire [15:0] bus_pin_in,
  output reg [15:0] bus_pin_out,
  output reg [15:0] bus_pin_oe,
  output wire [7:0] port1_pullup_en,
  output reg ready_pin_out,
  output reg ready_pin_oe,
  // serial mode configuration
  output wire idle_clock_polarity,
  output wire clock_phase_select,
  output wire select_active_level,
  output wire serial_aux_select,
  output wire serial_mosi,
  output wire serial_sclk,
  // default interrupt pin
  output reg int_pin_out,
  output reg int_pin_oe,
  output reg half_supply_en,
  // port 2
  input wire [7:0] port2_in,
  output reg [7:0] port2_out,
  output reg [7:0] port2_oe,
  output wire high_byte_write_n,
  // can line
  input wire rx_line_first,
  input wire rx_line_second,
  input wire tx_bit,
  output wire rx_bit,
  output wire tx_drive_first,
  output wire tx_drive_second,
  // clock output
  output wire programmable_clock_out
);
  reg [7:0] cpu_interface_config; // holds interrupt pin select
  reg [7:0] port1_setup_first; // port 1 setup, first location
  reg [7:0] port1_setup_second; // port 1 setup, second location
  reg [7:0] bus_config; // holds comparator bypass
  reg [7:0] port1_data; // port 1 output data
  reg [7:0] port2_data; // port 2 output data
  reg [7:0] port2_dir; // port 2 direction, 1 drives
  reg [CLK_DIV_W-1:0] clk_div_sel; // clock out divider
  reg p1_seen_first; // first setup location written
  reg p1_seen_second; // second setup location written
  wire int_pin_select; // interrupt relocation bit
  wire comparator_bypass; // comparator skip bit
  wire access_ok; // chip select asserted
  wire serial_mode; // serial interface selected
  wire p1_configured; // both setup locations written
  wire p1_is_port; // high pins act as port 1

  assign int_pin_select = cpu_interface_config[`CPM_BIT_INT_PIN_SEL];
  assign comparator_bypass = bus_config[`CPM_BIT_COMP_BYPASS];
  assign access_ok = ~chip_select_n;
  assign host_access = access_ok;
  assign serial_mode = (if_mode == `CPM_MODE_SERIAL);
  assign p1_configured = p1_seen_first & p1_seen_second;
  assign p1_is_port = (if_mode == `CPM_MODE_MUX8) | serial_mode;

  // match an offset against the register port address
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // register writes, gated by chip select
  always @(posedge core_clk) begin
    if (rst) begin
      cpu_interface_config <= `CPM_RST_CPU_IF;
      port1_setup_first <= `CPM_RST_BYTE;
      port1_setup_second <= `CPM_RST_BYTE;
      bus_config <= `CPM_RST_BYTE;
      port1_data <= `CPM_RST_BYTE;
      port2_data <= `CPM_RST_BYTE;
      port2_dir <= `CPM_RST_BYTE;
      clk_div_sel <= {CLK_DIV_W{1'b0}};
      p1_seen_first <= 1'b0;
      p1_seen_second <= 1'b0;
    end else if (reg_wr && access_ok) begin
      if (hit(reg_addr, `CPM_OFS_CPU_IF))
        cpu_interface_config <= reg_wdata;
      if (hit(reg_addr, `CPM_OFS_P1_SETUP_A)) begin
        port1_setup_first <= reg_wdata;
        p1_seen_first <= 1'b1;
      end
      if (hit(reg_addr, `CPM_OFS_P1_SETUP_B)) begin
        port1_setup_second <= reg_wdata;
        p1_seen_second <= 1'b1;
      end
      if (hit(reg_addr, `CPM_OFS_BUS_CFG))
        bus_config <= reg_wdata;
      if (hit(reg_addr, `CPM_OFS_P1_DATA))
        port1_data <= reg_wdata;
      if (hit(reg_addr, `CPM_OFS_P2_DATA))
        port2_data <= reg_wdata;
      if (hit(reg_addr, `CPM_OFS_P2_DIR))
        port2_dir <= reg_wdata;
      if (hit(reg_addr, `CPM_OFS_CLK_CFG))
        clk_div_sel <= reg_wdata[CLK_DIV_W-1:0];
    end
  end

  // register reads, pin levels shown for the ports
  always @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && access_ok) begin
      case (reg_addr)
        `CPM_OFS_CPU_IF: reg_rdata <= cpu_interface_config;
        `CPM_OFS_P1_SETUP_A: reg_rdata <= port1_setup_first;
        `CPM_OFS_P1_SETUP_B: reg_rdata <= port1_setup_second;
        `CPM_OFS_BUS_CFG: reg_rdata <= bus_config;
        `CPM_OFS_P1_DATA: reg_rdata <= bus_pin_in[15:8];
        `CPM_OFS_P2_DATA: reg_rdata <= port2_in;
        `CPM_OFS_P2_DIR: reg_rdata <= port2_dir;
        `CPM_OFS_CLK_CFG: reg_rdata <= {{(8-CLK_DIV_W){1'b0}}, clk_div_sel};
        default: reg_rdata <= 8'h00; // unmapped reads zero
      endcase
    end
  end

  // host bus inputs: low byte in every parallel mode, high byte by mode
  assign core_bus_in = {(p1_is_port ? 8'h00 : bus_pin_in[15:8]),
                        (serial_mode ? 8'h00 : bus_pin_in[7:0])};

  // serial mode configuration pins on the low byte
  assign idle_clock_polarity = serial_mode & bus_pin_in[0];
  assign clock_phase_select = serial_mode & bus_pin_in[1];
  assign select_active_level = serial_mode & bus_pin_in[2];
  assign serial_aux_select = serial_mode & bus_pin_in[3];
  assign serial_mosi = serial_mode & bus_pin_in[4];
  assign serial_sclk = serial_mode & bus_pin_in[6];

  // pull-ups on port 1 pins until configured
  assign port1_pullup_en = (p1_is_port && !p1_configured) ?
                           8'hff : 8'h00;

  // high byte write strobe only in 16-bit multiplexed mode
  assign high_byte_write_n = (if_mode == `CPM_MODE_MUX16) ?
                             port2_in[7] : 1'b1;

  // host bus pin drivers per mode
  always @(posedge core_clk) begin
    if (rst) begin
      bus_pin_out <= 16'h0000;
      bus_pin_oe <= 16'h0000;
    end else begin
      // low byte: driven only for reads in the multiplexed modes
      bus_pin_out[7:0] <= core_bus_out[7:0];
      if (!serial_mode && if_mode != `CPM_MODE_NONMUX8)
        bus_pin_oe[7:0] <= {8{core_bus_oe & access_ok}};
      else
        bus_pin_oe[7:0] <= 8'h00; // address only or serial inputs
      if (p1_is_port) begin
        // high byte as port 1 general io
        bus_pin_out[15:8] <= port1_data;
        bus_pin_oe[15:8] <= p1_configured ? port1_setup_first : 8'h00;
      end else begin
        // high byte as data or high address/data
        bus_pin_out[15:8] <= core_bus_out[15:8];
        bus_pin_oe[15:8] <= {8{core_bus_oe & access_ok}};
      end
    end
  end

  // readiness pin doubles as serial data out, open drain otherwise
  always @(posedge core_clk) begin
    if (rst) begin
      ready_pin_out <= 1'b0;
      ready_pin_oe <= 1'b0;
    end else if (serial_mode) begin
      ready_pin_out <= serial_data_out;
      ready_pin_oe <= access_ok;
    end else begin
      ready_pin_out <= 1'b0;
      ready_pin_oe <= access_ok & ~ready_in;
    end
  end

  // interrupt placement and port 2 drivers
  always @(posedge core_clk) begin
    if (rst) begin
      int_pin_out <= 1'b0;
      int_pin_oe <= 1'b0;
      half_supply_en <= 1'b0;
      port2_out <= 8'h00;
      port2_oe <= 8'h00;
    end else begin
      port2_out <= port2_data;
      port2_oe <= port2_dir;
      if (if_mode == `CPM_MODE_MUX16)
        port2_oe[7] <= 1'b0; // bit 7 is strobe input
      if (int_pin_select) begin
        // default pin gives half supply, interrupt on port 2 bit 6
        half_supply_en <= 1'b1;
        int_pin_out <= 1'b0;
        int_pin_oe <= 1'b0;
        port2_out[6] <= 1'b0;
        port2_oe[6] <= int_req;
      end else begin
        // open-drain low while interrupt pending
        half_supply_en <= 1'b0;
        int_pin_out <= 1'b0;
        int_pin_oe <= int_req;
      end
    end
  end

  // can line encoding
  cpm_line_codec u_codec (
    .core_clk(core_clk),
    .rst(rst),
    .rx_line_first(rx_line_first),
    .rx_line_second(rx_line_second),
    .comparator_bypass(comparator_bypass),
    .tx_bit(tx_bit),
    .rx_bit(rx_bit),
    .tx_drive_first(tx_drive_first),
    .tx_drive_second(tx_drive_second)
  );

  // programmable clock output
  cpm_clk_div #(.W(CLK_DIV_W)) u_clkdiv (
    .core_clk(core_clk),
    .rst(rst),
    .div_sel(clk_div_sel),
    .clk_level(programmable_clock_out),
    .tick()
  );
endmodule // cpm_pin_mux
`default_nettype wire

// File: dv/cpm_pin_mux_props.sv
/* checker for cpm_pin_mux: line codec, interrupt pin, chip select
 and pin mode relations. assumes one core_clk domain, bound below. */
`timescale 1ns/1ps
`default_nettype none
module cpm_pin_mux_props (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [1:0] if_mode,
  input wire logic chip_select_n,
  input wire logic host_access,
  input wire logic ready_pin_oe,
  input wire logic ready_pin_out,
  input wire logic serial_data_out,
  input wire logic int_req,
  input wire logic int_pin_out,
  input wire logic int_pin_oe,
  input wire logic half_supply_en,
  input wire logic [7:0] port2_out,
  input wire logic [7:0] port2_oe,
  input wire logic [15:0] bus_pin_in,
  input wire logic [15:0] core_bus_in,
  input wire logic rx_line_first,
  input wire logic rx_line_second,
  input wire logic tx_bit,
  input wire logic rx_bit,
  input wire logic tx_drive_first,
  input wire logic tx_drive_second
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // tx pair is the bit and its complement, one cycle on
  tx_pair_a: assert property (!$past(rst) |->
    tx_drive_first == $past(tx_bit) && tx_drive_second == !$past(tx_bit))
    else $error("tx pair wrong");
  // differing lines: level is the first line, bypassed or not
  rx_level_a: assert property (rx_line_first != rx_line_second |=>
    rx_bit == $past(rx_line_first)) else $error("rx level wrong");
  // default pin: pulled low only, follows the request
  int_home_a: assert property (!$past(rst) && !half_supply_en |->
    !int_pin_out && int_pin_oe == $past(int_req))
    else $error("int pin wrong");
  // relocated: port 2 bit 6 pulls low, default pin quiet
  int_moved_a: assert property (half_supply_en |-> !int_pin_oe &&
    !port2_out[6] && port2_oe[6] == $past(int_req))
    else $error("int not moved");
  // access and ready drive only under chip select
  cs_gate_a: assert property (host_access == !chip_select_n &&
    (!ready_pin_oe || !$past(chip_select_n))) else $error("cs gate wrong");
  low_pins_a: assert property (if_mode != 2'h3 |->
    core_bus_in[7:0] == bus_pin_in[7:0]) else $error("low pins wrong");
  high_pins_a: assert property (!if_mode[0] |->
    core_bus_in[15:8] == bus_pin_in[15:8]) else $error("high pins wrong");
  miso_out_a: assert property (if_mode == 2'h3 |=> if_mode != 2'h3 ||
    ready_pin_out == $past(serial_data_out)) else $error("miso wrong");
endmodule // cpm_pin_mux_props
bind cpm_pin_mux cpm_pin_mux_props cpm_pin_mux_props_i (.*);
`default_nettype wire

// File: dv/cpm_can_xcvr.sv
/* can transceiver model on the line pins.
 assumes the bench drives the far node request and line short. */
`timescale 1ns/1ps
`default_nettype none
module cpm_can_xcvr (
  input wire logic tx_drive_first,
  input wire logic tx_drive_second,
  input wire logic dom_req,
  input wire logic one_wire,
  output logic rx_line_first,
  output logic rx_line_second
);
  // wired bus: any node sending dominant wins
  wire logic dom = (~tx_drive_first & tx_drive_second) | dom_req;
  assign rx_line_first = ~dom;
  // a shorted pair leaves the comparator no difference
  assign rx_line_second = one_wire ? ~dom : dom;
endmodule // cpm_can_xcvr
`default_nettype wire

// File: dv/testbench.sv
/* self-checking bench for cpm_pin_mux: register tasks, line traffic
 through the transceiver model, mode sweep. needs cpm_regs.vh. */
`timescale 1ns/1ps
`default_nettype none
`include "cpm_regs.vh"
module testbench;
  logic core_clk, rst, chip_select_n, reg_wr, reg_rd, serial_data_out;
  logic int_req, tx_bit, dom_req, one_wire, v;
  logic [1:0] if_mode;
  logic [7:0] reg_addr, reg_wdata, port2_in;
  logic [15:0] bus_pin_in;
  wire [7:0] reg_rdata, port1_pullup_en, port2_out, port2_oe;
  wire [15:0] core_bus_in, bus_pin_out, bus_pin_oe;
  wire host_access, ready_pin_out, ready_pin_oe, int_pin_out, int_pin_oe;
  wire half_supply_en, high_byte_write_n, rx_line_first, rx_line_second;
  wire rx_bit, tx_drive_first, tx_drive_second, programmable_clock_out;
  wire idle_clock_polarity, clock_phase_select, select_active_level;
  wire serial_aux_select, serial_mosi, serial_sclk;
  int n_errors, n_compared, n_cycles;
  cpm_pin_mux cpm_pin_mux_i (.core_bus_out(16'h0000), .core_bus_oe(1'b0),
    .ready_in(1'b1), .high_byte_write_en(1'b0), .*);
  cpm_can_xcvr cpm_can_xcvr_i (.*);
  // 100 mhz core clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // hang guard
  always @(posedge core_clk) begin
    n_cycles++;
    if (n_cycles == 1000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // write, c is the chip select level; one idle cycle after
  task automatic wr(logic [7:0] a, logic [7:0] d, logic c);
    {reg_addr, reg_wdata, chip_select_n, reg_wr} = {a, d, c, 1'b1};
    cyc(1);
    {chip_select_n, reg_wr} = 2'b10;
    cyc(1);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    {reg_addr, chip_select_n, reg_rd} = {a, 2'b01};
    cyc(1);
    {chip_select_n, reg_rd} = 2'b10;
    cyc(1);
    chk("rdata", e, reg_rdata);
  endtask
  task automatic conclude();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    {rst, chip_select_n, reg_wr, reg_rd} = 4'b1100;
    {serial_data_out, int_req, tx_bit, dom_req, one_wire} = 5'b00100;
    {if_mode, reg_addr, reg_wdata, port2_in} = 26'h1000000;
    bus_pin_in = 16'h5aa5;
    cyc(3);
    rst = 1'b0; // host owns the long warm reset; bench keeps it short
    chk("tx", 16'h2, {tx_drive_first, tx_drive_second});
    rd(`CPM_OFS_CPU_IF, `CPM_RST_CPU_IF);
    tx_bit = 1'b0;
    cyc(1);
    chk("tx", 16'h1, {tx_drive_first, tx_drive_second});
    cyc(1);
    chk("rx", 16'h0, rx_bit);
    tx_bit = 1'b1;
    cyc(2);
    chk("rx", 16'h1, rx_bit);
    // shorted pair: comparator holds, bypass reads the first line
    {one_wire, dom_req} = 2'b11;
    cyc(2);
    chk("rx_hold", 16'h1, rx_bit);
    wr(`CPM_OFS_BUS_CFG, 8'h01, 1'b0);
    chk("rx_bypass", 16'h0, rx_bit);
    {one_wire, dom_req} = 2'b00;
    wr(`CPM_OFS_BUS_CFG, 8'h00, 1'b0);
    int_req = 1'b1;
    wr(`CPM_OFS_CPU_IF, 8'h20, 1'b1);
    chk("int_oe", 16'h1, int_pin_oe);
    rd(`CPM_OFS_CPU_IF, 8'h00);
    wr(`CPM_OFS_CPU_IF, 8'h20, 1'b0);
    chk("int_moved", 16'h6, {half_supply_en, port2_oe[6], port2_out[6]});
    chk("int_oe", 16'h0, int_pin_oe);
    rd(`CPM_OFS_CPU_IF, 8'h20);
    wr(`CPM_OFS_CPU_IF, 8'h00, 1'b0);
    chk("int_home", 16'h2, {int_pin_oe, int_pin_out});
    rd(8'h55, 8'h00);
    // sweep the interface mode straps
    for (int m = 0; m < 4; m++) begin
      if_mode = m[1:0];
      cyc(1);
      chk("low", m == 3 ? 16'h0 : 16'ha5, core_bus_in[7:0]);
      chk("high", m[0] ? 16'h0 : 16'h5a, core_bus_in[15:8]);
      chk("pullup", m[0] ? 16'hff : 16'h0, port1_pullup_en);
      chk("wrh", m == 0 ? 16'h0 : 16'h1, high_byte_write_n);
      chk("serial", m == 3 ? 16'h5 : 16'h0, {serial_sclk,
        serial_mosi, serial_aux_select, select_active_level,
        clock_phase_select, idle_clock_polarity});
    end
    serial_data_out = 1'b1;
    cyc(1);
    chk("miso", 16'h1, ready_pin_out);
    serial_data_out = 1'b0;
    cyc(1);
    chk("miso", 16'h0, ready_pin_out);
    if_mode = 2'h1;
    wr(`CPM_OFS_P1_SETUP_A, 8'h00, 1'b0);
    chk("pullup", 16'hff, port1_pullup_en);
    wr(`CPM_OFS_P1_SETUP_B, 8'h00, 1'b0);
    chk("pullup", 16'h0, port1_pullup_en);
    // port 1 drives its data, direction from the first setup byte
    wr(`CPM_OFS_P1_DATA, 8'h96, 1'b0);
    chk("p1_out", 16'h96, bus_pin_out[15:8]);
    chk("p1_oe", 16'h0, bus_pin_oe[15:8]);
    // port 2 general io outside 16-bit multiplexed mode
    wr(`CPM_OFS_P2_DIR, 8'hff, 1'b0);
    wr(`CPM_OFS_P2_DATA, 8'h3c, 1'b0);
    chk("p2", 16'hff3c, {port2_oe, port2_out});
    v = programmable_clock_out;
    cyc(1);
    chk("clk_out", v ? 16'h0 : 16'h1, programmable_clock_out);
    conclude();
  end
endmodule // testbench
`default_nettype wire
